// File: logic/pmvpd_regs.sv
// Capability registers: bridge extension, PM data, product-data capability header.
// Assumes one-cycle configuration read/write strobes on i_clk; the PM
// control/status body and product-data flag behaviour live in neighbouring logic.
`timescale 1ns/1ps
module pmvpd_regs (
    input  wire logic                     i_clk,
    input  wire logic                     i_sys_rst,
    input  wire pmvpd_pkg::pmvpd_cfg_req_t i_cfg_req,
    input  wire logic                     i_ctrl_en_cfg,
    input  wire logic                     i_d3_b2_sel_cfg,
    input  wire logic [1:0]               i_power_state_field,
    input  wire logic                     i_d3cold,
    input  wire logic [7:0]               i_pm_data_value,
    input  wire logic [15:0]              i_pi_addr_rdval,
    input  wire logic [31:0]              i_pi_word_rdval,
    output logic [31:0]                   o_cfg_rdata,
    output logic                          o_cfg_ack,
    output logic                          o_pi_addr_wr,
    output logic                          o_pi_word_wr,
    output logic                          o_pi_word_rd,
    output logic [31:0]                   o_pi_wdata,
    output logic [3:0]                    o_pi_byte_en,
    output pmvpd_pkg::pmvpd_sec_ctl_t     o_sec_ctl,
    output pmvpd_pkg::pmvpd_bstate_t      o_bus_state
);

    logic [7:0]                bridge_ext_r;
    logic [7:0]                pm_data_r;
    logic [1:0]                pstate_r;
    logic                      d3cold_r;
    pmvpd_pkg::pmvpd_bstate_t  bstate_nxt;
    pmvpd_pkg::pmvpd_bstate_t  bstate_r;
    logic [31:0]               rdata_nxt;

    // Word-aligned offset of a capability-relative byte offset
    function automatic logic [7:0] word_of(input logic [7:0] off);
        word_of = {off[7:2], 2'b00};
    endfunction : word_of

    // Extension byte mirrors strap-style config; bits 5..0 forced zero
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            bridge_ext_r <= pmvpd_pkg::RST_BRIDGE_EXT;
        end else begin
            bridge_ext_r <= 8'h00;
            bridge_ext_r[pmvpd_pkg::BIT_CTRL_EN]   <= i_ctrl_en_cfg;
            bridge_ext_r[pmvpd_pkg::BIT_D3_ACTION] <= i_d3_b2_sel_cfg;
        end
    end

    // Data byte tracks the selected reading; scaling left to software
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            pm_data_r <= pmvpd_pkg::RST_PM_DATA;
        end else begin
            pm_data_r <= i_pm_data_value;
        end
    end

    // Capture function power state and cold-state indication
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            pstate_r <= 2'h0;
            d3cold_r <= 1'b0;
        end else begin
            pstate_r <= i_power_state_field;
            d3cold_r <= i_d3cold;
        end
    end

    // Policy uses the registered bits, so bit 6 is ignored when bit 7 clear
    pmvpd_bus_policy u_policy (
        .i_ctrl_en   (bridge_ext_r[pmvpd_pkg::BIT_CTRL_EN]),
        .i_d3_b2_sel (bridge_ext_r[pmvpd_pkg::BIT_D3_ACTION]),
        .i_pstate    (pmvpd_pkg::pmvpd_pstate_t'(pstate_r)),
        .o_bstate    (bstate_nxt)
    );

    // Bus state and secondary controls; D3cold takes no bridge action
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            bstate_r  <= pmvpd_pkg::PMVPD_B0;
            o_sec_ctl <= '0;
        end else if (d3cold_r) begin
            bstate_r  <= pmvpd_pkg::PMVPD_B3;
            o_sec_ctl <= '0;
        end else begin
            bstate_r           <= bstate_nxt;
            o_sec_ctl.clk_stop <= (bstate_nxt == pmvpd_pkg::PMVPD_B2) ||
                                  (bstate_nxt == pmvpd_pkg::PMVPD_B3);
            o_sec_ctl.pwr_off  <= (bstate_nxt == pmvpd_pkg::PMVPD_B3);
        end
    end

    assign o_bus_state = bstate_r;

    // Read mux over the three dwords of the capability window
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (word_of(i_cfg_req.offset))
            word_of(pmvpd_pkg::OFF_BRIDGE_EXT): begin
                rdata_nxt = {pm_data_r, bridge_ext_r, 16'h0000};
            end
            word_of(pmvpd_pkg::OFF_PI_CAP_ID): begin
                rdata_nxt = {i_pi_addr_rdval, pmvpd_pkg::VAL_PI_NEXT,
                             pmvpd_pkg::VAL_PI_CAP_ID};
            end
            word_of(pmvpd_pkg::OFF_PI_WORD): begin
                rdata_nxt = i_pi_word_rdval;
            end
            default: begin
                rdata_nxt = 32'h0000_0000;
            end
        endcase
    end

    // Every access acks next cycle; read-only bytes just drop written data
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_cfg_ack   <= 1'b0;
            o_cfg_rdata <= 32'h0000_0000;
        end else begin
            o_cfg_ack   <= i_cfg_req.rd | i_cfg_req.wr;
            o_cfg_rdata <= i_cfg_req.rd ? rdata_nxt : 32'h0000_0000;
        end
    end

    // Strobes to the neighbouring product-data logic
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_pi_addr_wr <= 1'b0;
            o_pi_word_wr <= 1'b0;
            o_pi_word_rd <= 1'b0;
            o_pi_wdata   <= 32'h0000_0000;
            o_pi_byte_en <= 4'h0;
        end else begin
            o_pi_addr_wr <= i_cfg_req.wr && (i_cfg_req.byte_en[3:2] != 2'b00) &&
                            (word_of(i_cfg_req.offset) == word_of(pmvpd_pkg::OFF_PI_ADDR));
            o_pi_word_wr <= i_cfg_req.wr &&
                            (word_of(i_cfg_req.offset) == word_of(pmvpd_pkg::OFF_PI_WORD));
            o_pi_word_rd <= i_cfg_req.rd &&
                            (word_of(i_cfg_req.offset) == word_of(pmvpd_pkg::OFF_PI_WORD));
            o_pi_wdata   <= i_cfg_req.wdata;
            o_pi_byte_en <= i_cfg_req.byte_en;
        end
    end

    // Assertions
    property p_ext_reserved;
        @(posedge i_clk) disable iff (i_sys_rst) bridge_ext_r[5:0] == 6'h00;
    endproperty
    a_ext_reserved: assert property (p_ext_reserved)
        else $error("extension reserved bits not zero");

    property p_disabled_no_action;
        @(posedge i_clk) disable iff (i_sys_rst)
        !bridge_ext_r[pmvpd_pkg::BIT_CTRL_EN] && !d3cold_r |=> o_sec_ctl == '0;
    endproperty
    a_disabled_no_action: assert property (p_disabled_no_action)
        else $error("secondary bus touched while control disabled");

    property p_d3_b2;
        @(posedge i_clk) disable iff (i_sys_rst)
        bridge_ext_r[7:6] == 2'b11 && pstate_r == 2'h3 && !d3cold_r
        |=> o_sec_ctl.clk_stop && !o_sec_ctl.pwr_off;
    endproperty
    a_d3_b2: assert property (p_d3_b2)
        else $error("D3hot with B2 select did not stop clock only");

    property p_d3_b3;
        @(posedge i_clk) disable iff (i_sys_rst)
        bridge_ext_r[7:6] == 2'b10 && pstate_r == 2'h3 && !d3cold_r
        |=> o_sec_ctl.clk_stop && o_sec_ctl.pwr_off && bstate_r == pmvpd_pkg::PMVPD_B3;
    endproperty
    a_d3_b3: assert property (p_d3_b3)
        else $error("D3hot with B3 select did not remove power");

    property p_d2_clock;
        @(posedge i_clk) disable iff (i_sys_rst)
        bridge_ext_r[7] && pstate_r == 2'h2 && !d3cold_r
        |=> o_sec_ctl.clk_stop && !o_sec_ctl.pwr_off;
    endproperty
    a_d2_clock: assert property (p_d2_clock)
        else $error("D2 did not stop secondary clock");

    property p_d3cold_none;
        @(posedge i_clk) disable iff (i_sys_rst) d3cold_r |=> o_sec_ctl == '0;
    endproperty
    a_d3cold_none: assert property (p_d3cold_none)
        else $error("D3cold caused bridge action");

    sequence s_read_header;
        i_cfg_req.rd && word_of(i_cfg_req.offset) == 8'h08;
    endsequence
    property p_header_value;
        @(posedge i_clk) disable iff (i_sys_rst)
        s_read_header |=> o_cfg_ack && o_cfg_rdata[15:0] == 16'h0003;
    endproperty
    a_header_value: assert property (p_header_value)
        else $error("capability id or next pointer wrong");

    property p_data_follows;
        @(posedge i_clk) disable iff (i_sys_rst)
        !i_sys_rst |=> pm_data_r == $past(i_pm_data_value);
    endproperty
    a_data_follows: assert property (p_data_follows)
        else $error("data byte not tracking selected value");

    property p_write_acked;
        @(posedge i_clk) disable iff (i_sys_rst)
        i_cfg_req.wr |=> o_cfg_ack ##1 bridge_ext_r[5:0] == 6'h00;
    endproperty
    a_write_acked: assert property (p_write_acked)
        else $error("write not completed normally");

    // Reset leaves both bytes at reset values and every control quiet
    property p_reset_values;
        @(posedge i_clk)
        i_sys_rst |=> bridge_ext_r == pmvpd_pkg::RST_BRIDGE_EXT &&
                      pm_data_r == pmvpd_pkg::RST_PM_DATA && !o_cfg_ack &&
                      o_sec_ctl == '0 && bstate_r == pmvpd_pkg::PMVPD_B0;
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("reset values wrong");

    // Extension bits follow their sources one cycle late; guard skips the release edge
    property p_ext_mirrors;
        @(posedge i_clk) disable iff (i_sys_rst)
        !i_sys_rst |=> bridge_ext_r[pmvpd_pkg::BIT_CTRL_EN] == $past(i_ctrl_en_cfg) &&
                       bridge_ext_r[pmvpd_pkg::BIT_D3_ACTION] == $past(i_d3_b2_sel_cfg);
    endproperty
    a_ext_mirrors: assert property (p_ext_mirrors)
        else $error("extension bits not tracking their sources");

    // Bit 6 cannot move the bus while control is off
    property p_disabled_b0;
        @(posedge i_clk) disable iff (i_sys_rst)
        !bridge_ext_r[pmvpd_pkg::BIT_CTRL_EN] && !d3cold_r
        |=> bstate_r == pmvpd_pkg::PMVPD_B0;
    endproperty
    a_disabled_b0: assert property (p_disabled_b0)
        else $error("bus left B0 while control disabled");

    // Enabled D0 and D1 take no action on the secondary bus
    sequence s_enabled_live;
        bridge_ext_r[pmvpd_pkg::BIT_CTRL_EN] && !d3cold_r;
    endsequence
    property p_d0_idle;
        @(posedge i_clk) disable iff (i_sys_rst)
        s_enabled_live ##0 pstate_r == 2'h0
        |=> o_sec_ctl == '0 && bstate_r == pmvpd_pkg::PMVPD_B0;
    endproperty
    a_d0_idle: assert property (p_d0_idle)
        else $error("D0 did not map to idle B0");

    property p_d1_idle;
        @(posedge i_clk) disable iff (i_sys_rst)
        s_enabled_live ##0 pstate_r == 2'h1
        |=> o_sec_ctl == '0 && bstate_r == pmvpd_pkg::PMVPD_B1;
    endproperty
    a_d1_idle: assert property (p_d1_idle)
        else $error("D1 did not map to idle B1");

    // Every access gets its answer on the next edge
    sequence s_access;
        !i_sys_rst && (i_cfg_req.rd || i_cfg_req.wr);
    endsequence
    property p_access_ack;
        @(posedge i_clk) disable iff (i_sys_rst)
        s_access |=> o_cfg_ack;
    endproperty
    a_access_ack: assert property (p_access_ack)
        else $error("access not acknowledged");

    // Reads of the extension dword and of the product-data word
    sequence s_read_ext;
        !i_sys_rst && i_cfg_req.rd &&
        word_of(i_cfg_req.offset) == word_of(pmvpd_pkg::OFF_BRIDGE_EXT);
    endsequence
    property p_ext_read;
        @(posedge i_clk) disable iff (i_sys_rst)
        s_read_ext |=> o_cfg_rdata[31:24] == $past(pm_data_r) && o_cfg_rdata[21:0] == 22'h0;
    endproperty
    a_ext_read: assert property (p_ext_read)
        else $error("extension dword read wrong");

    sequence s_read_word;
        !i_sys_rst && i_cfg_req.rd &&
        word_of(i_cfg_req.offset) == word_of(pmvpd_pkg::OFF_PI_WORD);
    endsequence
    property p_word_read;
        @(posedge i_clk) disable iff (i_sys_rst)
        s_read_word |=> o_pi_word_rd && o_cfg_rdata == $past(i_pi_word_rdval);
    endproperty
    a_word_read: assert property (p_word_read)
        else $error("product-data word read wrong");

    // Address writes strobe the neighbour; read-only writes strobe nothing
    property p_addr_write;
        @(posedge i_clk) disable iff (i_sys_rst)
        !i_sys_rst && i_cfg_req.wr && i_cfg_req.byte_en[3:2] != 2'b00 &&
        word_of(i_cfg_req.offset) == word_of(pmvpd_pkg::OFF_PI_ADDR)
        |=> o_pi_addr_wr && o_pi_wdata == $past(i_cfg_req.wdata);
    endproperty
    a_addr_write: assert property (p_addr_write)
        else $error("address write not handed on");

    property p_ro_write;
        @(posedge i_clk) disable iff (i_sys_rst)
        !i_sys_rst && i_cfg_req.wr &&
        word_of(i_cfg_req.offset) == word_of(pmvpd_pkg::OFF_BRIDGE_EXT)
        |=> o_cfg_ack && !o_pi_addr_wr && !o_pi_word_wr;
    endproperty
    a_ro_write: assert property (p_ro_write)
        else $error("read-only write not dropped cleanly");

endmodule : pmvpd_regs

// File: logic/pmvpd_pkg.sv
// Package for the power-management extension and product-data capability block.
// Assumes a byte-addressed configuration access port relative to the capability base.
package pmvpd_pkg;

    // Capability-relative byte offsets
    localparam logic [7:0] OFF_BRIDGE_EXT   = 8'h06;
    localparam logic [7:0] OFF_PM_DATA      = 8'h07;
    localparam logic [7:0] OFF_PI_CAP_ID    = 8'h08;
    localparam logic [7:0] OFF_PI_NEXT      = 8'h09;
    localparam logic [7:0] OFF_PI_ADDR      = 8'h0a;
    localparam logic [7:0] OFF_PI_WORD      = 8'h0c;

    // Reset and fixed values
    localparam logic [7:0] RST_BRIDGE_EXT   = 8'h00;
    localparam logic [7:0] RST_PM_DATA      = 8'h00;
    localparam logic [7:0] VAL_PI_CAP_ID    = 8'h03;
    localparam logic [7:0] VAL_PI_NEXT      = 8'h00;
    localparam logic [15:0] RST_PI_ADDR     = 16'h0000;
    localparam logic [31:0] RST_PI_WORD     = 32'h0000_0000;

    // Field positions in the bridge extension byte
    localparam int BIT_CTRL_EN    = 7;
    localparam int BIT_D3_ACTION  = 6;

    // Power state field encodings
    typedef enum logic [1:0] {
        PMVPD_D0    = 2'h0,
        PMVPD_D1    = 2'h1,
        PMVPD_D2    = 2'h2,
        PMVPD_D3HOT = 2'h3
    } pmvpd_pstate_t;

    // Secondary bus states, Gray ordered B0-B1-B2-B3
    typedef enum logic [1:0] {
        PMVPD_B0 = 2'h0,
        PMVPD_B1 = 2'h1,
        PMVPD_B2 = 2'h3,
        PMVPD_B3 = 2'h2
    } pmvpd_bstate_t;

    // Configuration access request
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  offset;
        logic [3:0]  byte_en;
        logic [31:0] wdata;
    } pmvpd_cfg_req_t;

    // Secondary bus control outputs
    typedef struct packed {
        logic clk_stop;
        logic pwr_off;
    } pmvpd_sec_ctl_t;

endpackage : pmvpd_pkg

// File: logic/pmvpd_bus_policy.sv
// Secondary bus policy: maps function power state to bus state.
// Assumes same-clock inputs from the control/status and extension registers.
`timescale 1ns/1ps
module pmvpd_bus_policy (
    input  wire logic                    i_ctrl_en,
    input  wire logic                    i_d3_b2_sel,
    input  wire pmvpd_pkg::pmvpd_pstate_t i_pstate,
    output pmvpd_pkg::pmvpd_bstate_t     o_bstate
);

    // Disabled policy leaves bus at B0 whatever software writes
    always_comb begin
        o_bstate = pmvpd_pkg::PMVPD_B0;
        if (i_ctrl_en) begin
            case (i_pstate)
                pmvpd_pkg::PMVPD_D0:    o_bstate = pmvpd_pkg::PMVPD_B0;
                pmvpd_pkg::PMVPD_D1:    o_bstate = pmvpd_pkg::PMVPD_B1;
                pmvpd_pkg::PMVPD_D2:    o_bstate = pmvpd_pkg::PMVPD_B2;
                pmvpd_pkg::PMVPD_D3HOT: begin
                    if (i_d3_b2_sel) begin
                        o_bstate = pmvpd_pkg::PMVPD_B2;
                    end else begin
                        o_bstate = pmvpd_pkg::PMVPD_B3;
                    end
                end
                default:                o_bstate = pmvpd_pkg::PMVPD_B0;
            endcase
        end
    end

endmodule : pmvpd_bus_policy

// File: tb/pmvpd_regs_tb_top.sv
// Self-checking bench for the capability register block and its bus policy.
// Assumes the block's own assertions are bound inside the design files.
`timescale 1ns/1ps
module pmvpd_regs_tb_top;
    typedef struct packed {
        logic                     en;
        logic                     sel;
        pmvpd_pkg::pmvpd_pstate_t ps;
        logic                     cold;
        pmvpd_pkg::pmvpd_bstate_t bs;
        logic                     clk_stop;
        logic                     pwr_off;
    } pmvpd_row_t;
    // Policy table: control inputs beside the expected bus outputs
    pmvpd_row_t rows [8] = '{
        '{1'b0, 1'b1, pmvpd_pkg::PMVPD_D3HOT, 1'b0, pmvpd_pkg::PMVPD_B0, 1'b0, 1'b0},
        '{1'b0, 1'b0, pmvpd_pkg::PMVPD_D2, 1'b0, pmvpd_pkg::PMVPD_B0, 1'b0, 1'b0},
        '{1'b1, 1'b0, pmvpd_pkg::PMVPD_D0, 1'b0, pmvpd_pkg::PMVPD_B0, 1'b0, 1'b0},
        '{1'b1, 1'b1, pmvpd_pkg::PMVPD_D1, 1'b0, pmvpd_pkg::PMVPD_B1, 1'b0, 1'b0},
        '{1'b1, 1'b0, pmvpd_pkg::PMVPD_D2, 1'b0, pmvpd_pkg::PMVPD_B2, 1'b1, 1'b0},
        '{1'b1, 1'b1, pmvpd_pkg::PMVPD_D3HOT, 1'b0, pmvpd_pkg::PMVPD_B2, 1'b1, 1'b0},
        '{1'b1, 1'b0, pmvpd_pkg::PMVPD_D3HOT, 1'b0, pmvpd_pkg::PMVPD_B3, 1'b1, 1'b1},
        '{1'b1, 1'b0, pmvpd_pkg::PMVPD_D3HOT, 1'b1, pmvpd_pkg::PMVPD_B3, 1'b0, 1'b0}};
    logic                      i_clk = 1'b0;
    logic                      i_sys_rst = 1'b1;
    pmvpd_pkg::pmvpd_cfg_req_t req = '0;
    logic                      en = 1'b1;
    logic                      sel = 1'b1;
    logic [1:0]                ps = 2'h2;
    logic                      cold = 1'b0;
    logic [7:0]                pm_data = 8'hff;
    logic [15:0]               addr_val = 16'h5a3c;
    logic [31:0]               word_val = 32'hc3a5_1e0f;
    logic [31:0]               o_cfg_rdata;
    logic                      o_cfg_ack;
    logic                      o_pi_addr_wr;
    logic                      o_pi_word_wr;
    logic                      o_pi_word_rd;
    logic [31:0]               o_pi_wdata;
    logic [3:0]                o_pi_byte_en;
    pmvpd_pkg::pmvpd_sec_ctl_t o_sec_ctl;
    pmvpd_pkg::pmvpd_bstate_t  o_bus_state;
    int                        n_mismatch = 0;
    int                        check_count = 0;
    logic [3:0]                exp_bus;
    logic [31:0]               exp_word;
    wire [3:0] flags = {o_cfg_ack, o_pi_addr_wr, o_pi_word_wr, o_pi_word_rd};
    wire [3:0] bus = {o_bus_state, o_sec_ctl.clk_stop, o_sec_ctl.pwr_off};

    always #25 i_clk = ~i_clk;

    pmvpd_regs pmvpd_regs_i (
        .i_clk               (i_clk),
        .i_sys_rst           (i_sys_rst),
        .i_cfg_req           (req),
        .i_ctrl_en_cfg       (en),
        .i_d3_b2_sel_cfg     (sel),
        .i_power_state_field (ps),
        .i_d3cold            (cold),
        .i_pm_data_value     (pm_data),
        .i_pi_addr_rdval     (addr_val),
        .i_pi_word_rdval     (word_val),
        .o_cfg_rdata         (o_cfg_rdata),
        .o_cfg_ack           (o_cfg_ack),
        .o_pi_addr_wr        (o_pi_addr_wr),
        .o_pi_word_wr        (o_pi_word_wr),
        .o_pi_word_rd        (o_pi_word_rd),
        .o_pi_wdata          (o_pi_wdata),
        .o_pi_byte_en        (o_pi_byte_en),
        .o_sec_ctl           (o_sec_ctl),
        .o_bus_state         (o_bus_state)
    );

    // Compare a data word
    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: data %h, expected %h", $time, got, exp);
        end
    endtask : chk_data

    // Compare a group of flags or a bus-state nibble
    task automatic chk_flags(input logic [3:0] got, input logic [3:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: flags %b, expected %b", $time, got, exp);
        end
    endtask : chk_flags

    // One access: request for one cycle, answer looked at in the ack cycle
    task automatic cfg(input logic r, input logic w, input logic [7:0] off,
                       input logic [3:0] be, input logic [31:0] wd);
        @(posedge i_clk);
        req <= '{rd: r, wr: w, offset: off, byte_en: be, wdata: wd};
        @(posedge i_clk);
        req <= '0;
        @(negedge i_clk);
    endtask : cfg

    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : print_verdict

    initial begin
        // Reset with busy-looking inputs: everything must stay quiet
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(negedge i_clk);
        chk_flags(flags, 4'h0);
        chk_flags(bus, {pmvpd_pkg::PMVPD_B0, 2'b00});
        chk_data(o_cfg_rdata, 32'h0);
        $display("test reset done");
        // Policy rows, with the extension and data bytes read back each time
        foreach (rows[k]) begin
            @(posedge i_clk);
            en <= rows[k].en;
            sel <= rows[k].sel;
            ps <= rows[k].ps;
            cold <= rows[k].cold;
            pm_data <= 8'h10 + 8'(k);
            repeat (3) @(posedge i_clk);
            @(negedge i_clk);
            exp_bus = {rows[k].bs, rows[k].clk_stop, rows[k].pwr_off};
            chk_flags(bus, exp_bus);
            cfg(1'b1, 1'b0, pmvpd_pkg::OFF_BRIDGE_EXT & 8'hfc, 4'hf, 32'h0);
            chk_flags(flags, 4'h8);
            // Raw byte expected: scaling is software's business
            exp_word = {8'h10 + 8'(k), rows[k].en, rows[k].sel, 22'h0};
            chk_data(o_cfg_rdata, exp_word);
        end
        $display("test policy table done");
        // Product-data header and word reads
        cfg(1'b1, 1'b0, pmvpd_pkg::OFF_PI_CAP_ID, 4'hf, 32'h0);
        chk_data(o_cfg_rdata, {addr_val, 16'h0003});
        cfg(1'b1, 1'b0, pmvpd_pkg::OFF_PI_WORD, 4'hf, 32'h0);
        chk_data(o_cfg_rdata, word_val);
        chk_flags(flags, 4'h9);
        cfg(1'b1, 1'b0, 8'h10, 4'hf, 32'h0);
        chk_data(o_cfg_rdata, 32'h0);
        $display("test header reads done");
        // Writes to read-only bytes: acknowledged, no strobe, values kept
        cfg(1'b0, 1'b1, 8'h04, 4'hf, 32'hffff_ffff);
        chk_flags(flags, 4'h8);
        cfg(1'b0, 1'b1, 8'h08, 4'h3, 32'hffff_ffff);
        chk_flags(flags, 4'h8);
        cfg(1'b1, 1'b0, 8'h08, 4'hf, 32'h0);
        chk_data(o_cfg_rdata, {addr_val, 16'h0003});
        cfg(1'b1, 1'b0, 8'h04, 4'hf, 32'h0);
        chk_data(o_cfg_rdata, {8'h17, 8'h80, 16'h0});
        $display("test read-only writes done");
        // Address and word writes hand their strobes to the neighbour
        cfg(1'b0, 1'b1, 8'h08, 4'hc, 32'h8123_0000);
        chk_flags(flags, 4'hc);
        chk_data(o_pi_wdata, 32'h8123_0000);
        chk_flags(o_pi_byte_en, 4'hc);
        cfg(1'b0, 1'b1, 8'h0c, 4'hf, 32'h0bad_f00d);
        chk_flags(flags, 4'ha);
        chk_data(o_pi_wdata, 32'h0bad_f00d);
        $display("test product-data writes done");
        // Mid-run reset with a read standing: answers stay quiet, bus back to B0
        @(posedge i_clk);
        i_sys_rst <= 1'b1;
        req <= '{rd: 1'b1, wr: 1'b0, offset: 8'h04, byte_en: 4'hf, wdata: 32'h0};
        @(posedge i_clk);
        req <= '0;
        @(negedge i_clk);
        chk_flags(flags, 4'h0);
        chk_flags(bus, {pmvpd_pkg::PMVPD_B0, 2'b00});
        chk_data(o_cfg_rdata, 32'h0);
        @(posedge i_clk);
        i_sys_rst <= 1'b0;
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        chk_flags(bus, {pmvpd_pkg::PMVPD_B3, 2'b00});
        $display("test mid-run reset done");
        print_verdict();
    end
endmodule : pmvpd_regs_tb_top
